//--- design/pdsc_pkg.sv
// Package for the PHY power-down and speed control register bank.
// Assumes 16-bit management registers addressed by a 5-bit register index.
package pdsc_pkg;
    // Register indices
    localparam logic [4:0] REG_SLEEP_CS = 5'h15;
    localparam logic [4:0] REG_SPEED_CTL = 5'h16;
    localparam logic [4:0] REG_SPEED_CTL3 = 5'h17;
    // Field positions in energy_sleep_ctrl_status
    localparam int BIT_SLEEP_EN = 3;
    localparam int BIT_WAKE_PULSE_EN = 2;
    localparam int BIT_IN_SLEEP = 1;
    localparam int BIT_SPARE0 = 0;
    // Field positions in link_speed_clock_ctrl; RETRY_LSB is in REG_SPEED_CTL3
    localparam int BIT_HD_CRS_EN = 15;
    localparam int BIT_FALLBACK_EN = 10;
    localparam int RETRY_LSB = 10;
    // Reset values
    localparam logic [15:0] RST_SLEEP_CS = 16'h0000;
    localparam logic [15:0] RST_SPEED_CTL = 16'h0308;
    localparam logic [15:0] RST_SPEED_CTL3 = 16'h3048;
    // Writable masks; RST_RETRY is the reset retry count
    localparam logic [15:0] WMASK_SLEEP_CS = 16'h000d;
    localparam logic [2:0] RST_RETRY = 3'h4;
    // Timing: quiet time before sleeping and wake pulse period
    localparam int CLK_HZ = 25_000_000;
    localparam int QUIET_S = 3;
    localparam int QUIET_CYC = QUIET_S * CLK_HZ;
    localparam int WAKE_MS = 1000;
    localparam int WAKE_CYC = WAKE_MS * (CLK_HZ / 1000);
    localparam int PULSE_CYC = 16;
    // Link attempt time before declaring a failure
    localparam int LINK_TRY_MS = 2000;
    localparam int LINK_TRY_CYC = LINK_TRY_MS * (CLK_HZ / 1000);

    typedef struct packed {
        logic wr;
        logic [4:0] addr;
        logic [15:0] wdata;
    } pdsc_req_s;

    typedef struct packed {
        logic sleep_en;
        logic wake_en;
    } pdsc_strap_s;

    typedef enum logic [1:0] {
        LS_HIGH,
        LS_LOW,
        LS_UP
    } pdsc_link_e;
endpackage : pdsc_pkg

//--- design/pdsc_timer.sv
// Reloadable down-counter giving a one-cycle done pulse.
// Assumes a single clock and synchronous start/clear controls.
`timescale 1ns/1ns
`default_nettype none
module pdsc_timer #(
    parameter int WIDTH = 32
) (
    input wire logic mclk,
    input wire logic rst,
    input wire logic clr,
    input wire logic start,
    input wire logic [WIDTH-1:0] load,
    output logic busy,
    output logic done
);
    logic [WIDTH-1:0] cnt_r;
    logic busy_r;
    logic done_r;

    ////////////////////////////////////////////////////////////////////////
    // Start reloads; clear wins so a stale timeout never fires
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            cnt_r <= '0;
            busy_r <= 1'b0;
            done_r <= 1'b0;
        end else if (clr) begin
            busy_r <= 1'b0;
            done_r <= 1'b0;
        end else if (start) begin
            cnt_r <= load;
            busy_r <= 1'b1;
            done_r <= 1'b0;
        end else if (busy_r && cnt_r <= WIDTH'(1)) begin
            busy_r <= 1'b0;
            done_r <= 1'b1;
        end else begin
            cnt_r <= busy_r ? cnt_r - WIDTH'(1) : cnt_r;
            done_r <= 1'b0;
        end
    end

    assign busy = busy_r;
    assign done = done_r;
endmodule : pdsc_timer
`default_nettype wire

//--- design/pdsc_regs.sv
// Power-down and speed control register bank of a 10/100 PHY.
// Assumes a management frame engine presents one register access per
// mgmt_strobe, and line energy and link status arrive synchronous to mclk.
`timescale 1ns/1ns
`default_nettype none
module pdsc_regs #(
    parameter int QUIET_CYCLES = pdsc_pkg::QUIET_CYC,
    parameter int WAKE_CYCLES = pdsc_pkg::WAKE_CYC,
    parameter int LINK_CYCLES = pdsc_pkg::LINK_TRY_CYC
) (
    input wire logic mclk,
    input wire logic rst,
    input wire logic mgmt_strobe,
    input wire pdsc_pkg::pdsc_req_s mgmt_req,
    output logic [15:0] mgmt_rdata,
    output logic mgmt_hit,
    input wire pdsc_pkg::pdsc_strap_s strap,
    input wire logic line_energy,
    input wire logic an_enable,
    input wire logic adv_10m,
    input wire logic link_up,
    input wire logic half_duplex,
    input wire logic mac_tx_en,
    input wire logic rx_carrier,
    output logic crs,
    output logic in_sleep,
    output logic wake_pulse,
    output logic speed_10m,
    output logic link_restart
);
    logic [15:0] sleep_cs_r;
    logic [15:0] speed_ctl_r;
    logic [15:0] speed_ctl3_r;
    logic strap_done_r;
    logic in_sleep_r;
    logic speed_10m_r;
    logic crs_r;
    logic [2:0] tries_r;
    logic [2:0] tries_nxt;
    logic [7:0] pulse_r;
    pdsc_pkg::pdsc_link_e link_r;
    pdsc_pkg::pdsc_link_e link_nxt;

    wire wr_sleep = mgmt_strobe && mgmt_req.wr
        && mgmt_req.addr == pdsc_pkg::REG_SLEEP_CS;
    wire wr_speed = mgmt_strobe && mgmt_req.wr
        && mgmt_req.addr == pdsc_pkg::REG_SPEED_CTL;
    wire wr_speed3 = mgmt_strobe && mgmt_req.wr
        && mgmt_req.addr == pdsc_pkg::REG_SPEED_CTL3;
    wire sleep_en = sleep_cs_r[pdsc_pkg::BIT_SLEEP_EN];
    wire wake_en = sleep_cs_r[pdsc_pkg::BIT_WAKE_PULSE_EN];
    wire fb_en = speed_ctl_r[pdsc_pkg::BIT_FALLBACK_EN];
    wire [2:0] retry = speed_ctl3_r[pdsc_pkg::RETRY_LSB +: 3];

    ////////////////////////////////////////////////////////////////////////
    // Register writes; straps are caught on the first clock after reset
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            sleep_cs_r <= pdsc_pkg::RST_SLEEP_CS;
            speed_ctl_r <= pdsc_pkg::RST_SPEED_CTL;
            speed_ctl3_r <= pdsc_pkg::RST_SPEED_CTL3;
            strap_done_r <= 1'b0;
        end else if (!strap_done_r) begin
            strap_done_r <= 1'b1;
            sleep_cs_r[pdsc_pkg::BIT_SLEEP_EN] <= strap.sleep_en;
            sleep_cs_r[pdsc_pkg::BIT_WAKE_PULSE_EN] <= strap.wake_en;
        end else begin
            if (wr_sleep) begin
                // Status and reserved bits are not stored
                sleep_cs_r <= mgmt_req.wdata & pdsc_pkg::WMASK_SLEEP_CS;
            end
            if (wr_speed) begin
                speed_ctl_r <= mgmt_req.wdata;
            end
            if (wr_speed3) begin
                speed_ctl3_r <= {2'h0, mgmt_req.wdata[13:0]};
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Energy-detect power-down: quiet timer and wake pulse timer
    logic quiet_done;
    logic quiet_busy;
    logic wake_done;
    wire quiet_clr = !sleep_en || line_energy || in_sleep_r;
    wire quiet_start = !quiet_busy && !quiet_done && !quiet_clr;

    pdsc_timer #(.WIDTH(32)) u_quiet (
        .mclk(mclk),
        .rst(rst),
        .clr(quiet_clr),
        .start(quiet_start),
        .load(32'(QUIET_CYCLES)),
        .busy(quiet_busy),
        .done(quiet_done)
    );

    logic wake_busy;
    wire wake_clr = !in_sleep_r || !wake_en;
    pdsc_timer #(.WIDTH(32)) u_wake (
        .mclk(mclk),
        .rst(rst),
        .clr(wake_clr),
        .start(!wake_clr && !wake_busy),
        .load(32'(WAKE_CYCLES)),
        .busy(wake_busy),
        .done(wake_done)
    );

    // Sleep state; energy or disable exits at once
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            in_sleep_r <= 1'b0;
        end else if (!sleep_en || line_energy) begin
            in_sleep_r <= 1'b0;
        end else if (quiet_done) begin
            in_sleep_r <= 1'b1;
        end
    end

    // Pulse burst length; avoids both ends sleeping forever.
    // A burst is cut on the same edge that power-down is left, so no
    // stray pulse is ever launched outside power-down.
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            pulse_r <= 8'h00;
        end else if (wake_clr || !sleep_en || line_energy) begin
            pulse_r <= 8'h00;
        end else if (wake_done) begin
            pulse_r <= 8'(pdsc_pkg::PULSE_CYC);
        end else if (pulse_r != 8'h00) begin
            pulse_r <= pulse_r - 8'h01;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Carrier sense toward the MAC
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            crs_r <= 1'b0;
        end else begin
            crs_r <= rx_carrier || (mac_tx_en && half_duplex
                && speed_ctl_r[pdsc_pkg::BIT_HD_CRS_EN]);
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Speed fallback: count failed link attempts at the high speed
    logic try_done;
    logic try_busy;
    wire try_clr = link_up || link_r != pdsc_pkg::LS_HIGH || !an_enable;
    pdsc_timer #(.WIDTH(32)) u_try (
        .mclk(mclk),
        .rst(rst),
        .clr(try_clr),
        .start(!try_clr && !try_busy && !try_done),
        .load(32'(LINK_CYCLES)),
        .busy(try_busy),
        .done(try_done)
    );

    // Fallback needs the enable, autonegotiation and 10M advertised
    wire fb_ok = fb_en && an_enable && adv_10m;

    always_comb begin
        link_nxt = link_r;
        tries_nxt = tries_r;
        case (link_r)
            pdsc_pkg::LS_HIGH: begin
                if (link_up) begin
                    link_nxt = pdsc_pkg::LS_UP;
                    tries_nxt = 3'h0;
                end else if (try_done && fb_ok) begin
                    if (tries_r >= retry) begin
                        link_nxt = pdsc_pkg::LS_LOW;
                        tries_nxt = 3'h0;
                    end else begin
                        tries_nxt = tries_r + 3'h1;
                    end
                end
            end
            pdsc_pkg::LS_LOW: begin
                if (!fb_ok) begin
                    link_nxt = pdsc_pkg::LS_HIGH;
                end else if (link_up) begin
                    link_nxt = pdsc_pkg::LS_UP;
                end
            end
            pdsc_pkg::LS_UP: begin
                if (!link_up) begin
                    link_nxt = pdsc_pkg::LS_HIGH;
                end
            end
            default: link_nxt = pdsc_pkg::LS_HIGH;
        endcase
    end

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            link_r <= pdsc_pkg::LS_HIGH;
            tries_r <= 3'h0;
            speed_10m_r <= 1'b0;
        end else begin
            link_r <= link_nxt;
            tries_r <= tries_nxt;
            if (link_r == pdsc_pkg::LS_HIGH) begin
                speed_10m_r <= 1'b0;
            end else if (link_nxt == pdsc_pkg::LS_LOW) begin
                speed_10m_r <= 1'b1;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Read mux; upper status field is always zero
    wire [15:0] sleep_rd = {12'h000, sleep_cs_r[3:2], in_sleep_r,
        sleep_cs_r[pdsc_pkg::BIT_SPARE0]};

    always_comb begin
        case (mgmt_req.addr)
            pdsc_pkg::REG_SLEEP_CS: mgmt_rdata = sleep_rd;
            pdsc_pkg::REG_SPEED_CTL: mgmt_rdata = speed_ctl_r;
            pdsc_pkg::REG_SPEED_CTL3: mgmt_rdata = speed_ctl3_r;
            default: mgmt_rdata = 16'h0000;
        endcase
    end

    assign mgmt_hit = mgmt_req.addr == pdsc_pkg::REG_SLEEP_CS
        || mgmt_req.addr == pdsc_pkg::REG_SPEED_CTL
        || mgmt_req.addr == pdsc_pkg::REG_SPEED_CTL3;
    assign crs = crs_r;
    assign in_sleep = in_sleep_r;
    assign wake_pulse = pulse_r != 8'h00;
    assign speed_10m = speed_10m_r;
    assign link_restart = try_done;
endmodule : pdsc_regs
`default_nettype wire

//--- sim/pdsc_chk.sv
// Port checker for the power-down and speed control register bank.
// Assumes the bind at the foot attaches it to every pdsc_regs instance.
`timescale 1ns/1ns
`default_nettype none
module pdsc_chk (
    input wire logic mclk,
    input wire logic rst,
    input wire pdsc_pkg::pdsc_req_s mgmt_req,
    input wire logic [15:0] mgmt_rdata,
    input wire logic line_energy,
    input wire logic an_enable,
    input wire logic adv_10m,
    input wire logic rx_carrier,
    input wire logic crs,
    input wire logic in_sleep,
    input wire logic wake_pulse,
    input wire logic speed_10m,
    input wire logic link_restart
);
    default clocking @(posedge mclk); endclocking
    default disable iff (rst);
    // Read of the status register selected
    wire logic sel_cs = mgmt_req.addr == pdsc_pkg::REG_SLEEP_CS;
    //////////////////////////////////////
    // A burst is 16 cycles high, then low, unless power-down ends first
    sequence s_burst;
        ##15 (wake_pulse || !in_sleep) ##1 !wake_pulse;
    endsequence
    property p_burst; $rose(wake_pulse) |-> s_burst; endproperty
    property p_wake_sleep; $rose(wake_pulse) |-> in_sleep; endproperty
    property p_rsvd; sel_cs |-> mgmt_rdata[15:4] == 12'h000; endproperty
    property p_stat; sel_cs |-> mgmt_rdata[1] == in_sleep; endproperty
    property p_energy; line_energy |=> !in_sleep; endproperty
    property p_crs; rx_carrier |=> crs; endproperty
    property p_restart; link_restart |=> !link_restart; endproperty
    property p_fall; $rose(speed_10m) |-> $past(adv_10m && an_enable);
    endproperty
    a_burst: assert property (p_burst)
        else $error("wake burst length wrong");
    a_wake_sleep: assert property (p_wake_sleep)
        else $error("wake burst outside power-down");
    a_rsvd: assert property (p_rsvd)
        else $error("status upper field not zero");
    a_stat: assert property (p_stat)
        else $error("status bit differs from state");
    a_energy: assert property (p_energy)
        else $error("power-down held with line energy");
    a_crs: assert property (p_crs)
        else $error("carrier sense missing");
    a_restart: assert property (p_restart)
        else $error("restart pulse too long");
    a_fall: assert property (p_fall)
        else $error("fallback without its conditions");
endmodule : pdsc_chk
bind pdsc_regs pdsc_chk u_chk (.mclk, .rst, .mgmt_req, .mgmt_rdata,
    .line_energy, .an_enable, .adv_10m, .rx_carrier, .crs, .in_sleep,
    .wake_pulse, .speed_10m, .link_restart);
`default_nettype wire

//--- sim/pdsc_host.sv
// Management host model: one register access per task call.
// Assumes calls are made after reset, from one process at a time.
`timescale 1ns/1ns
`default_nettype none
module pdsc_host (
    input wire logic mclk,
    input wire logic [15:0] mgmt_rdata,
    output logic mgmt_strobe,
    output pdsc_pkg::pdsc_req_s mgmt_req
);
    initial begin
        mgmt_strobe = 1'b0;
        mgmt_req = 22'h000000;
    end
    // Launch after an edge, hold until the taking edge, then release
    task automatic access(input logic wr, input logic [4:0] a,
        input logic [15:0] d, output logic [15:0] q);
        @(posedge mclk);
        #2;
        mgmt_strobe = 1'b1;
        mgmt_req = '{wr, a, d};
        @(posedge mclk);
        q = mgmt_rdata;
        #2;
        mgmt_strobe = 1'b0;
        mgmt_req.wdata = ~d; // Released data must not look valid
    endtask : access
endmodule : pdsc_host
`default_nettype wire

//--- sim/pdsc_regs_tb.sv
// Self-checking bench for the power-down and speed control bank.
// Assumes the host model and the bound checker are compiled first.
`timescale 1ns/1ns
`default_nettype none
module pdsc_regs_tb;
    logic mclk, rst, mgmt_strobe, mgmt_hit, line_energy, an_enable;
    logic adv_10m, link_up, half_duplex, mac_tx_en, rx_carrier, crs;
    logic in_sleep, wake_pulse, speed_10m, link_restart;
    logic [15:0] mgmt_rdata, q;
    pdsc_pkg::pdsc_req_s mgmt_req;
    pdsc_pkg::pdsc_strap_s strap;
    int bad_count, checked, n;
    // Short timers keep the run brief; waits below are bounded
    pdsc_regs #(.QUIET_CYCLES(20), .WAKE_CYCLES(20), .LINK_CYCLES(20)) dut (
        .mclk, .rst, .mgmt_strobe, .mgmt_req, .mgmt_rdata, .mgmt_hit,
        .strap, .line_energy, .an_enable, .adv_10m, .link_up, .half_duplex,
        .mac_tx_en, .rx_carrier, .crs, .in_sleep, .wake_pulse, .speed_10m,
        .link_restart);
    pdsc_host host (.mclk, .mgmt_rdata, .mgmt_strobe, .mgmt_req);
    //////////////////////////////////////
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        checked++;
        if (got !== exp) begin
            bad_count++;
            $display("unexpected at %0t: got %h want %h", $time, got, exp);
        end
    endtask : chk
    task automatic rd(input logic [4:0] a, input logic [15:0] exp);
        host.access(1'b0, a, 16'h0000, q);
        chk(q, exp);
    endtask : rd
    task automatic wr(input logic [4:0] a, input logic [15:0] d);
        host.access(1'b1, a, d, q);
    endtask : wr
    task automatic step;
        @(posedge mclk);
        #2;
    endtask : step
    task automatic complete_run;
        $display("Comparisons %0d, mismatches %0d", checked, bad_count);
        if (bad_count == 0 && checked > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : complete_run
    //////////////////////////////////////
    initial begin
        mclk = 1'b0;
        forever #20 mclk = ~mclk;
    end
    // Whole run needs about 700 cycles; allow over six times that
    initial begin
        #180000;
        bad_count++;
        complete_run();
    end
    initial begin
        {rst, line_energy, strap} = 4'hf;
        {an_enable, adv_10m, link_up, half_duplex} = 4'h0;
        {mac_tx_en, rx_carrier, bad_count, checked} = '0;
        repeat (4) @(posedge mclk);
        #2;
        rst = 1'b0;
        rd(pdsc_pkg::REG_SLEEP_CS, 16'h000c);
        rd(pdsc_pkg::REG_SPEED_CTL, 16'h0308);
        chk({15'h0, mgmt_hit}, 16'h0001);
        rd(pdsc_pkg::REG_SPEED_CTL3, 16'h3048);
        rd(5'h10, 16'h0000);
        chk({15'h0, mgmt_hit}, 16'h0000);
        wr(pdsc_pkg::REG_SLEEP_CS, 16'hffff);
        rd(pdsc_pkg::REG_SLEEP_CS, 16'h000d);
        // Quiet line: sleep, report it, send a wake burst, wake on energy
        line_energy = 1'b0;
        for (n = 0; n < 200 && in_sleep !== 1'b1; n++) step();
        chk({15'h0, in_sleep}, 16'h0001);
        rd(pdsc_pkg::REG_SLEEP_CS, 16'h000f);
        for (n = 0; n < 200 && wake_pulse !== 1'b1; n++) step();
        chk({15'h0, wake_pulse}, 16'h0001);
        for (n = 0; n < 40 && wake_pulse !== 1'b0; n++) step();
        line_energy = 1'b1;
        step();
        chk({15'h0, in_sleep}, 16'h0000);
        // Pulses off: sleep again but no burst
        wr(pdsc_pkg::REG_SLEEP_CS, 16'h0009);
        line_energy = 1'b0;
        for (n = 0; n < 200 && in_sleep !== 1'b1; n++) step();
        n = 0;
        repeat (80) begin
            step();
            n += wake_pulse;
        end
        chk(n[15:0], 16'h0000);
        wr(pdsc_pkg::REG_SLEEP_CS, 16'h0001);
        step();
        chk({15'h0, in_sleep}, 16'h0000);
        repeat (80) step();
        chk({15'h0, in_sleep}, 16'h0000);
        // Carrier sense on own transmit only in half duplex
        {mac_tx_en, line_energy} = 2'h3;
        wr(pdsc_pkg::REG_SPEED_CTL, 16'h8708);
        step();
        chk({15'h0, crs}, 16'h0000);
        half_duplex = 1'b1;
        step();
        step();
        chk({15'h0, crs}, 16'h0001);
        wr(pdsc_pkg::REG_SPEED_CTL, 16'h0708);
        step();
        chk({15'h0, crs}, 16'h0000);
        // Receive carrier still reaches the MAC with the option off
        rx_carrier = 1'b1;
        step();
        step();
        chk({15'h0, crs}, 16'h0001);
        rx_carrier = 1'b0;
        // Fallback after retry count plus one failed attempts
        {an_enable, adv_10m} = 2'h3;
        n = 0;
        for (int i = 0; i < 1000 && speed_10m !== 1'b1; i++) begin
            step();
            n += link_restart;
        end
        chk(n[15:0], 16'h0005);
        chk({15'h0, speed_10m}, 16'h0001);
        an_enable = 1'b0;
        repeat (5) step();
        chk({15'h0, speed_10m}, 16'h0000);
        {an_enable, adv_10m} = 2'h2;
        repeat (300) step();
        chk({15'h0, speed_10m}, 16'h0000);
        complete_run();
    end
endmodule : pdsc_regs_tb
`default_nettype wire
